// ===== irs_map.svh
// Constants for the serial register-access slave: address, strap code, counts.
// Assumes inclusion by the design file only.
`ifndef IRS_MAP_SVH
`define IRS_MAP_SVH

`define IRS_SLAVE_ADDR 7'h0A
`define IRS_MODE_I2C 2'h2
`define IRS_BITS_PER_BYTE 4'h8
`define IRS_LAST_BIT 4'h7
`define IRS_LAST_BYTE 2'h3
`define IRS_FIRST_BYTE 2'h0
`define IRS_IDX_ONE 8'h01
`define IRS_DWORD_PAD 2'h0
`define IRS_ZERO_WORD 32'h0000_0000
`define IRS_SYNC_STAGES 3

`endif

// ===== irs_pkg.sv
// Types shared by the serial register-access slave.
// Assumes irs_map.svh is on the include path.
package irs_pkg;
    typedef enum {L_IDLE, L_RX, L_RX_ACK, L_TX_WAIT, L_TX, L_TX_ACK, L_IGNORE} irs_lstate_t;
    typedef enum {P_CTRL, P_REGADR, P_WDATA} irs_phase_t;
    typedef enum {K_RD, K_WR, K_DONE} irs_kind_t;
    typedef enum {C_IDLE, C_WAIT} irs_cstate_t;
    localparam int unsigned IDX_W = 8;
endpackage : irs_pkg

// ===== irs_slave.sv
// Two-wire serial slave that gives an outside master word access to the internal register bus.
// Assumes open-drain pads outside, a free-running LINK_CLK well above the serial clock,
// and an internal register bus that answers each request with one REG_ACK cycle.
`timescale 1ns/1ps
`default_nettype none
`include "irs_map.svh"

module irs_slave (
    // Clocks, reset and enable
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CORE_CE,
    input wire logic LINK_CLK,
    // Management mode straps
    input wire logic [1:0] MNGT_MODE,
    // Serial pins
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE,
    // Internal register bus
    output logic [irs_pkg::IDX_W+1:0] REG_ADDR,
    output logic [31:0] REG_WDATA,
    output logic REG_RD_REQ,
    output logic REG_WR_REQ,
    output logic REG_RD_DONE,
    input wire logic REG_ACK,
    input wire logic REG_HIT,
    input wire logic [31:0] REG_RD_DATA,
    // Status
    output logic I2C_ENABLED
);
    import irs_pkg::*;

    // Core domain state
    logic strap_done_ff;
    logic en_ff;
    logic [2:0] req_sync_ff;
    logic req_c_ff;
    logic req_seen_ff;
    logic ack_tgl_ff;
    logic [31:0] rd_hold_ff;
    irs_cstate_t cst_ff;
    irs_kind_t ckind_ff;

    // Link domain state
    logic [1:0] rst_lk_ff;
    logic rst_lk_n;
    localparam int NSYNC = 5;
    logic [NSYNC-1:0] s1_ff, s2_ff, s3_ff, filt_ff;
    logic scl_q_ff, sda_q_ff;
    irs_lstate_t st_ff;
    irs_phase_t ph_ff;
    logic [3:0] bit_cnt_ff;
    logic [1:0] byte_cnt_ff;
    logic [7:0] sh_ff;
    logic [31:0] tx_ff;
    logic [23:0] wbuf_ff;
    logic [IDX_W-1:0] idx_ff;
    logic rw_ff, mack_ff, multi_ff, one_done_ff, asked_ff, sda_oe_ff;
    logic req_tgl_ff;
    irs_kind_t lkind_ff;
    logic [IDX_W-1:0] lidx_ff;
    logic [31:0] lwdata_ff;

    // Filtered link-side views
    logic scl_f, sda_f, en_lk, ack_lk, ce_lk;
    assign scl_f = filt_ff[0];
    assign sda_f = filt_ff[1];
    assign en_lk = filt_ff[2];
    assign ack_lk = filt_ff[3];
    assign ce_lk = filt_ff[4];

    logic scl_rise, scl_fall, start_c, stop_c, busy, byte_in;
    logic wr_go, dn_go, rd_go;
    assign scl_rise = scl_f & ~scl_q_ff;
    assign scl_fall = ~scl_f & scl_q_ff;
    assign start_c = scl_f & scl_q_ff & sda_q_ff & ~sda_f;
    assign stop_c = scl_f & scl_q_ff & ~sda_q_ff & sda_f;
    assign busy = req_tgl_ff != ack_lk;
    assign byte_in = st_ff == L_RX && scl_fall && bit_cnt_ff == `IRS_BITS_PER_BYTE;
    // Scl is low at these moments, so a start or stop cannot coincide with them
    assign wr_go = ce_lk && en_lk && byte_in && ph_ff == P_WDATA && byte_cnt_ff == `IRS_LAST_BYTE;
    assign dn_go = ce_lk && en_lk && st_ff == L_TX_ACK && scl_fall && byte_cnt_ff == `IRS_LAST_BYTE;
    assign rd_go = ce_lk && en_lk && !start_c && !stop_c && st_ff == L_TX_WAIT && !asked_ff && !busy;

    assign SDA_O = 1'b0;
    assign SDA_OE = sda_oe_ff;
    assign I2C_ENABLED = en_ff;

    // Strap catch: sampled once, on the first enabled edge after reset release
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            strap_done_ff <= 1'b0;
            en_ff <= 1'b0;
        end else if (CORE_CE && !strap_done_ff) begin
            strap_done_ff <= 1'b1;
            en_ff <= MNGT_MODE == `IRS_MODE_I2C;
        end
    end

    // Request toggle from the link: three stages, counted once the last two agree
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            req_sync_ff <= 3'h0;
            req_c_ff <= 1'b0;
        end else begin
            req_sync_ff <= {req_sync_ff[1:0], req_tgl_ff};
            if (req_sync_ff[1] == req_sync_ff[2]) begin
                req_c_ff <= req_sync_ff[2];
            end
        end
    end

    // Register bus master; payload from the link is stable until the answer toggles back
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cst_ff <= C_IDLE;
            ckind_ff <= K_RD;
            req_seen_ff <= 1'b0;
            ack_tgl_ff <= 1'b0;
            rd_hold_ff <= `IRS_ZERO_WORD;
            REG_ADDR <= '0;
            REG_WDATA <= `IRS_ZERO_WORD;
            REG_RD_REQ <= 1'b0;
            REG_WR_REQ <= 1'b0;
            REG_RD_DONE <= 1'b0;
        end else if (CORE_CE) begin
            REG_RD_DONE <= 1'b0;
            case (cst_ff)
                C_IDLE: begin
                    if (req_c_ff != req_seen_ff) begin
                        req_seen_ff <= req_c_ff;
                        ckind_ff <= lkind_ff;
                        REG_ADDR <= {lidx_ff, `IRS_DWORD_PAD};
                        case (lkind_ff)
                            K_RD: begin
                                REG_RD_REQ <= 1'b1;
                                cst_ff <= C_WAIT;
                            end
                            K_WR: begin
                                REG_WDATA <= lwdata_ff;
                                REG_WR_REQ <= 1'b1;
                                cst_ff <= C_WAIT;
                            end
                            default: begin
                                REG_RD_DONE <= 1'b1;
                                ack_tgl_ff <= ~ack_tgl_ff;
                            end
                        endcase
                    end
                end
                C_WAIT: begin
                    if (REG_ACK) begin
                        REG_RD_REQ <= 1'b0;
                        REG_WR_REQ <= 1'b0;
                        if (ckind_ff == K_RD) begin
                            // Whole word held here so the shift never sees a half-updated value
                            rd_hold_ff <= REG_HIT ? REG_RD_DATA : `IRS_ZERO_WORD;
                        end
                        ack_tgl_ff <= ~ack_tgl_ff;
                        cst_ff <= C_IDLE;
                    end
                end
                default: cst_ff <= C_IDLE;
            endcase
        end
    end

    // Link reset: asserted at once, released on the link clock
    always_ff @(posedge LINK_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_lk_ff <= 2'h0;
        end else begin
            rst_lk_ff <= {rst_lk_ff[0], 1'b1};
        end
    end
    assign rst_lk_n = rst_lk_ff[1];

    // Pin and cross-domain levels; the filters are never frozen so the enable can return
    logic [NSYNC-1:0] raw_in;
    assign raw_in = {CORE_CE, ack_tgl_ff, en_ff, SDA_I, SCL_I};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge LINK_CLK or negedge rst_lk_n) begin
                if (!rst_lk_n) begin
                    s1_ff[gi] <= 1'b0;
                    s2_ff[gi] <= 1'b0;
                    s3_ff[gi] <= 1'b0;
                    filt_ff[gi] <= (gi < 2) ? 1'b1 : 1'b0;
                end else begin
                    s1_ff[gi] <= raw_in[gi];
                    s2_ff[gi] <= s1_ff[gi];
                    s3_ff[gi] <= s2_ff[gi];
                    if (s2_ff[gi] == s3_ff[gi]) begin
                        filt_ff[gi] <= s3_ff[gi];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge LINK_CLK or negedge rst_lk_n) begin
        if (!rst_lk_n) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end else if (ce_lk) begin
            scl_q_ff <= scl_f;
            sda_q_ff <= sda_f;
        end
    end

    // Protocol engine
    always_ff @(posedge LINK_CLK or negedge rst_lk_n) begin
        if (!rst_lk_n) begin
            st_ff <= L_IDLE;
            ph_ff <= P_CTRL;
            bit_cnt_ff <= 4'h0;
            byte_cnt_ff <= 2'h0;
            sh_ff <= 8'h00;
            tx_ff <= `IRS_ZERO_WORD;
            wbuf_ff <= 24'h00_0000;
            idx_ff <= '0;
            rw_ff <= 1'b0;
            mack_ff <= 1'b0;
            multi_ff <= 1'b0;
            one_done_ff <= 1'b0;
            asked_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else if (ce_lk) begin
            if (!en_lk) begin
                st_ff <= L_IDLE;
                sda_oe_ff <= 1'b0;
            end else if (start_c) begin
                // Partial word is simply dropped: the bus only sees whole words
                st_ff <= L_RX;
                ph_ff <= P_CTRL;
                bit_cnt_ff <= 4'h0;
                byte_cnt_ff <= `IRS_FIRST_BYTE;
                multi_ff <= 1'b0;
                one_done_ff <= 1'b0;
                asked_ff <= 1'b0;
                sda_oe_ff <= 1'b0;
            end else if (stop_c) begin
                st_ff <= L_IDLE;
                sda_oe_ff <= 1'b0;
            end else begin
                case (st_ff)
                    L_RX: begin
                        if (scl_rise && bit_cnt_ff != `IRS_BITS_PER_BYTE) begin
                            sh_ff <= {sh_ff[6:0], sda_f};
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end else if (byte_in) begin
                            bit_cnt_ff <= 4'h0;
                            st_ff <= L_RX_ACK;
                            sda_oe_ff <= 1'b1;
                            case (ph_ff)
                                P_CTRL: begin
                                    if (sh_ff[7:1] == `IRS_SLAVE_ADDR) begin
                                        rw_ff <= sh_ff[0];
                                    end else begin
                                        st_ff <= L_IGNORE;
                                        sda_oe_ff <= 1'b0;
                                    end
                                end
                                P_REGADR: idx_ff <= sh_ff;
                                default: begin
                                    wbuf_ff <= {wbuf_ff[15:0], sh_ff};
                                    byte_cnt_ff <= byte_cnt_ff + 2'h1;
                                    if (byte_cnt_ff == `IRS_FIRST_BYTE && one_done_ff && !multi_ff) begin
                                        // Second register begins: step past the first one
                                        idx_ff <= idx_ff + `IRS_IDX_ONE;
                                        multi_ff <= 1'b1;
                                    end
                                    if (byte_cnt_ff == `IRS_LAST_BYTE) begin
                                        one_done_ff <= 1'b1;
                                        if (multi_ff) begin
                                            idx_ff <= idx_ff + `IRS_IDX_ONE;
                                        end
                                    end
                                end
                            endcase
                        end
                    end
                    L_RX_ACK: begin
                        if (scl_fall) begin
                            sda_oe_ff <= 1'b0;
                            if (ph_ff == P_CTRL && rw_ff) begin
                                st_ff <= L_TX_WAIT;
                                byte_cnt_ff <= `IRS_FIRST_BYTE;
                                asked_ff <= 1'b0;
                            end else begin
                                st_ff <= L_RX;
                                ph_ff <= (ph_ff == P_CTRL) ? P_REGADR : P_WDATA;
                            end
                        end
                    end
                    L_TX_WAIT: begin
                        if (rd_go) begin
                            asked_ff <= 1'b1;
                        end else if (asked_ff && !busy) begin
                            // Scl is still low here; a slow bus answer only delays the first bit
                            tx_ff <= rd_hold_ff;
                            sda_oe_ff <= ~rd_hold_ff[31];
                            bit_cnt_ff <= 4'h0;
                            byte_cnt_ff <= `IRS_FIRST_BYTE;
                            st_ff <= L_TX;
                        end
                    end
                    L_TX: begin
                        if (scl_fall) begin
                            tx_ff <= {tx_ff[30:0], 1'b0};
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                            if (bit_cnt_ff == `IRS_LAST_BIT) begin
                                sda_oe_ff <= 1'b0;
                                st_ff <= L_TX_ACK;
                            end else begin
                                sda_oe_ff <= ~tx_ff[30];
                            end
                        end
                    end
                    L_TX_ACK: begin
                        if (scl_rise) begin
                            mack_ff <= ~sda_f;
                        end else if (scl_fall) begin
                            bit_cnt_ff <= 4'h0;
                            if (byte_cnt_ff == `IRS_LAST_BYTE) begin
                                if (mack_ff || multi_ff) begin
                                    idx_ff <= idx_ff + `IRS_IDX_ONE;
                                end
                                if (mack_ff) begin
                                    multi_ff <= 1'b1;
                                    asked_ff <= 1'b0;
                                    st_ff <= L_TX_WAIT;
                                end else begin
                                    st_ff <= L_IGNORE;
                                end
                            end else if (mack_ff) begin
                                byte_cnt_ff <= byte_cnt_ff + 2'h1;
                                sda_oe_ff <= ~tx_ff[31];
                                st_ff <= L_TX;
                            end else begin
                                st_ff <= L_IGNORE;
                            end
                        end
                    end
                    L_IDLE, L_IGNORE: ;
                    default: st_ff <= L_IDLE;
                endcase
            end
        end
    end

    // Requests to the core: payload is frozen until the answer toggle returns
    always_ff @(posedge LINK_CLK or negedge rst_lk_n) begin
        if (!rst_lk_n) begin
            req_tgl_ff <= 1'b0;
            lkind_ff <= K_RD;
            lidx_ff <= '0;
            lwdata_ff <= `IRS_ZERO_WORD;
        end else if (wr_go || dn_go || rd_go) begin
            req_tgl_ff <= ~req_tgl_ff;
            lidx_ff <= idx_ff;
            lkind_ff <= wr_go ? K_WR : (dn_go ? K_DONE : K_RD);
            lwdata_ff <= {wbuf_ff, sh_ff};
        end
    end

    // Checks on the link side
    default clocking cb_lk @(posedge LINK_CLK);
    endclocking
    default disable iff (!rst_lk_n);

    a_strap_gate_idle: assert property (ce_lk && !en_lk |=> st_ff == L_IDLE && !sda_oe_ff)
        else $error("engine active while disabled");
    a_addr_mismatch_ign: assert property (byte_in && ce_lk && en_lk && ph_ff == P_CTRL
        && sh_ff[7:1] != `IRS_SLAVE_ADDR |=> st_ff == L_IGNORE && !sda_oe_ff)
        else $error("foreign address not ignored");
    a_regaddr_load: assert property (byte_in && ce_lk && en_lk && ph_ff == P_REGADR
        |=> idx_ff == $past(sh_ff) && sda_oe_ff)
        else $error("register index not taken");
    a_stop_aborts: assert property (ce_lk && en_lk && stop_c |=> st_ff == L_IDLE && !sda_oe_ff)
        else $error("stop did not abort");
    a_read_starts: assert property (ce_lk && en_lk && !start_c && !stop_c && st_ff == L_RX_ACK
        && scl_fall && ph_ff == P_CTRL && rw_ff |=> st_ff == L_TX_WAIT ##1 rd_go || asked_ff)
        else $error("read did not start");
    a_single_read_keep: assert property (dn_go && !mack_ff && !multi_ff |=> idx_ff == $past(idx_ff))
        else $error("single read moved index");
    a_multi_read_incr: assert property (dn_go && (mack_ff || multi_ff)
        |=> idx_ff == $past(idx_ff) + `IRS_IDX_ONE)
        else $error("multiple read did not step index");
    a_nack_stops_tx: assert property (ce_lk && en_lk && st_ff == L_TX_ACK && scl_fall
        && byte_cnt_ff != `IRS_LAST_BYTE && !mack_ff |=> st_ff == L_IGNORE ##1 !sda_oe_ff)
        else $error("sending continued after refusal");
    a_write_whole_word: assert property (wr_go |=> lkind_ff == K_WR && lwdata_ff == $past({wbuf_ff, sh_ff}))
        else $error("write word not passed on");
    a_ack_drives_low: assert property (st_ff == L_RX_ACK |-> sda_oe_ff)
        else $error("acknowledge not driven");

    // Checks on the core side, then covers on the link side
    a_unimpl_zero: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        CORE_CE && cst_ff == C_WAIT && REG_ACK && ckind_ff == K_RD && !REG_HIT
        |=> rd_hold_ff == `IRS_ZERO_WORD)
        else $error("unimplemented read not zero");
    a_done_is_pulse: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        REG_RD_DONE |=> !REG_RD_DONE)
        else $error("side effect strobe too long");

    c_single_read: cover property (dn_go && !mack_ff);
    c_multi_read: cover property (dn_go && mack_ff);
    c_multi_write: cover property (wr_go && multi_ff);
    c_early_nack: cover property (st_ff == L_TX_ACK && scl_fall && byte_cnt_ff != `IRS_LAST_BYTE && !mack_ff);
endmodule : irs_slave
`default_nettype wire

// ===== irs_mst.sv
// Behavioural two-wire bus master standing in for the host processor.
// Assumes the bench resolves the data wire from all pull-down enables plus a pull-up.
`timescale 1ns/1ps
`default_nettype none
module irs_mst (
    // Bus pins
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // Quarter of a bit period at the fast-mode rate
    localparam time Q = 625ns;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic start_cond;
        sda_low = 1'b0;
        #Q scl = 1'b1;
        #Q sda_low = 1'b1;
        #Q scl = 1'b0;
        #Q;
    endtask : start_cond
    task automatic stop_cond;
        sda_low = 1'b1;
        #Q scl = 1'b1;
        #Q sda_low = 1'b0;
        #Q;
    endtask : stop_cond
    task automatic bit_out(input logic b);
        sda_low = !b;
        #Q scl = 1'b1;
        #(2*Q) scl = 1'b0;
        #Q;
    endtask : bit_out
    task automatic bit_in(output logic b);
        sda_low = 1'b0;
        #Q scl = 1'b1;
        #Q b = sda;
        #Q scl = 1'b0;
        #Q;
    endtask : bit_in
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i]);
        end
        bit_in(a);
        ack = !a;
    endtask : wbyte
    // Last byte of a read is refused by the caller, then a stop follows
    task automatic rbyte(output logic [7:0] d, input logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_in(d[i]);
        end
        bit_out(!ack);
    endtask : rbyte
endmodule : irs_mst
`default_nettype wire

// ===== irs_slave_tb.sv
// Self-checking bench for the serial register-access slave.
// Assumes irs_map.svh on the include path; the bench answers the register bus.
`timescale 1ns/1ps
`default_nettype none
module irs_slave_tb;
    import irs_pkg::*;
    logic core_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [1:0] mode = 2'b00;
    logic ack = 1'b0;
    logic hit = 1'b0;
    logic [31:0] rdata = 32'h0000_0000;
    logic sda_o, sda_oe, rd_req, wr_req, rd_done, enabled;
    logic [IDX_W+1:0] addr, wr_addr;
    logic [31:0] wdata, wr_val;
    wire scl, sda_low;
    // Open drain with pull-up: low when any party pulls
    wire sda = !(sda_low || sda_oe);
    int n_fail = 0;
    int check_count = 0;
    int wr_cnt = 0;
    int done_cnt = 0;
    initial forever #5 core_clk = ~core_clk;
    initial begin
        #3.3;
        forever #7.5 link_clk = ~link_clk;
    end
    irs_slave u_irs_slave (.CORE_CLK(core_clk), .RST_N(rst_n), .CORE_CE(ce), .LINK_CLK(link_clk),
        .MNGT_MODE(mode), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_RD_REQ(rd_req), .REG_WR_REQ(wr_req), .REG_RD_DONE(rd_done),
        .REG_ACK(ack), .REG_HIT(hit), .REG_RD_DATA(rdata), .I2C_ENABLED(enabled));
    irs_mst u_mst (.scl(scl), .sda_low(sda_low), .sda(sda));
    // Register file stand-in: below 0x100 implemented, data derived from address
    always @(posedge core_clk) begin
        ack <= 1'b0;
        if ((rd_req || wr_req) && !ack) begin
            ack <= 1'b1;
            hit <= addr < 10'h100;
            rdata <= 32'hC0DE_0000 | {22'h0, addr};
            if (wr_req) begin
                wr_cnt++;
                wr_addr <= addr;
                wr_val <= wdata;
            end
        end
        if (rd_done) begin
            done_cnt++;
        end
    end
    function automatic logic [31:0] expv(input logic [9:0] a);
        return (a < 10'h100) ? (32'hC0DE_0000 | {22'h0, a}) : 32'h0000_0000;
    endfunction : expv
    task automatic conclude;
        if (n_fail == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic send(input logic [7:0] d, input logic exp_ack);
        logic a;
        u_mst.wbyte(d, a);
        chk({31'h0, a}, {31'h0, exp_ack});
    endtask : send
    task automatic rd_word(input logic last, output logic [31:0] w);
        logic [7:0] b;
        for (int i = 0; i < 4; i++) begin
            u_mst.rbyte(b, !(last && i == 3));
            w = {w[23:0], b};
        end
    endtask : rd_word
    task automatic do_reset(input logic [1:0] m);
        @(posedge core_clk);
        rst_n <= 1'b0;
        mode <= m;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (200) @(posedge core_clk);
        chk({31'h0, enabled}, {31'h0, m == 2'b10});
    endtask : do_reset
    task automatic sc_disabled;
        do_reset(2'b01);
        u_mst.start_cond();
        send(8'h14, 1'b0);
        u_mst.stop_cond();
        do_reset(2'b10);
        u_mst.start_cond();
        send(8'h16, 1'b0);
        send(8'h14, 1'b0);
        u_mst.stop_cond();
    endtask : sc_disabled
    task automatic sc_write;
        int n0 = wr_cnt;
        logic [63:0] d = 64'h1234_5678_9ABC_DEF0;
        u_mst.start_cond();
        send(8'h14, 1'b1);
        send(8'h05, 1'b1);
        for (int i = 0; i < 8; i++) begin
            send(d[63:56], 1'b1);
            d = d << 8;
        end
        u_mst.stop_cond();
        chk(32'(wr_cnt - n0), 32'h0000_0002);
        chk({22'h0, wr_addr}, 32'h0000_0018);
        chk(wr_val, 32'h9ABC_DEF0);
    endtask : sc_write
    task automatic sc_read;
        int n0 = done_cnt;
        logic [31:0] w;
        logic [7:0] b;
        logic x;
        u_mst.start_cond();
        send(8'h15, 1'b1);
        rd_word(1'b0, w);
        chk(w, expv(10'h01C));
        rd_word(1'b1, w);
        chk(w, expv(10'h020));
        u_mst.stop_cond();
        chk(32'(done_cnt - n0), 32'h0000_0002);
        // Refusal on the first byte: slave must let go of the wire
        u_mst.start_cond();
        send(8'h15, 1'b1);
        u_mst.rbyte(b, 1'b0);
        u_mst.bit_in(x);
        chk({31'h0, x}, 32'h0000_0001);
        u_mst.stop_cond();
        chk(32'(done_cnt - n0), 32'h0000_0002);
    endtask : sc_read
    task automatic sc_abort_wrap;
        int n0 = wr_cnt;
        logic [31:0] w;
        u_mst.start_cond();
        send(8'h14, 1'b1);
        send(8'h09, 1'b1);
        send(8'hAB, 1'b1);
        send(8'hCD, 1'b1);
        u_mst.stop_cond();
        chk(32'(wr_cnt - n0), 32'h0000_0000);
        u_mst.start_cond();
        send(8'h14, 1'b1);
        send(8'hFF, 1'b1);
        u_mst.start_cond();
        send(8'h15, 1'b1);
        rd_word(1'b0, w);
        chk(w, 32'h0000_0000);
        rd_word(1'b1, w);
        chk(w, expv(10'h000));
        u_mst.stop_cond();
        chk(32'(wr_cnt - n0), 32'h0000_0000);
    endtask : sc_abort_wrap
    initial begin
        #990us;
        n_fail++;
        conclude();
    end
    initial begin
        sc_disabled();
        sc_write();
        sc_read();
        sc_abort_wrap();
        conclude();
    end
endmodule : irs_slave_tb
`default_nettype wire
